//--- design/rxca_pkg.sv
// shared constants, types and the register map of the receive channel assessment block
package rxca_pkg;
  // register port geometry
  localparam int RXCA_ADDR_W = 8;
  localparam int RXCA_DATA_W = 32;

  // register byte offsets
  localparam logic [7:0] OFF_CONFIG = 8'h00;
  localparam logic [7:0] OFF_THRESH = 8'h04;
  localparam logic [7:0] OFF_HOP_STEP = 8'h08;
  localparam logic [7:0] OFF_HOP_CHAN = 8'h0c;
  localparam logic [7:0] OFF_BASE_FREQ = 8'h10;
  localparam logic [7:0] OFF_DBM_CAL = 8'h14;
  localparam logic [7:0] OFF_SYM_PERIOD = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_STRENGTH = 8'h20;

  // config register field positions
  localparam int CFG_AVG_LSB = 0;
  localparam int CFG_CAP_LSB = 4;
  localparam int CFG_WIN_LSB = 8;
  localparam int CFG_CDR_LSB = 12;
  localparam int CFG_MUTE_BIT = 16;
  localparam int CFG_IRQ_SRC_BIT = 17;
  localparam int CFG_EXT_SRC_BIT = 18;
  localparam int CFG_DOUT_PIN_LSB = 20;
  localparam int CFG_CLK_PIN_LSB = 24;

  // values after reset
  localparam logic [31:0] CONFIG_RST = 32'h0210_0100;
  localparam logic [7:0] THRESH_RST = 8'h50;
  localparam logic [7:0] DBM_CAL_RST = 8'h80;
  localparam logic [15:0] SYM_PERIOD_RST = 16'h00fa;
  localparam logic [31:0] BASE_FREQ_RST = 32'h0000_0000;

  // hop arithmetic: frequency word counts in 500 Hz steps
  localparam int HOP_UNIT_HZ = 2500;
  localparam int FREQ_LSB_HZ = 500;
  localparam logic [7:0] HOP_MULT = 8'(HOP_UNIT_HZ / FREQ_LSB_HZ);

  // averaging filter fraction bits and tracking tolerance (5/32 = 15.6 %)
  localparam int FILT_FRAC = 7;
  localparam int TRACK_TOL_NUM = 5;
  localparam int TRACK_TOL_SHIFT = 5;

  typedef enum logic [1:0] {CAP_REALTIME, CAP_PREAMBLE, CAP_SYNC, CAP_PACKET} rxca_capture_t;
  typedef enum logic [1:0] {CDR_COUNTING, CDR_TRACKING, CDR_MANCHESTER, CDR_SPARE} rxca_cdr_t;

  // samples and events from the demodulator front-end
  typedef struct packed {
    logic [6:0] i_level;
    logic [6:0] q_level;
    logic sample_vld;
    logic demod_bit;
    logic bit_vld;
    logic dev_ok;
    logic snr_ok;
    logic fsk_mode;
    logic direct_mode;
    logic preamble_det;
    logic sync_det;
    logic packet_done;
  } rxca_demod_t;
endpackage : rxca_pkg

//--- design/rxca_top.sv
// receive channel assessment: strength, phase jumps, clock recovery and hop frequency
// Notes on behaviour
// - raw strength is the sum of the I and Q log amplifier levels
// - samples pass an averaging filter whose order is a three-bit field
// - filtered code is translated to dBm; code and dBm are both readable
// - two-bit select: real time, or latched at preamble, sync or packet end
// - real-time strength above the eight-bit threshold gives 1, else 0
// - threshold result can feed the signal-valid interrupt and receive extension
// - every 0-to-1 or 1-to-0 change of demodulated data is one phase jump
// - two-bit window field selects how many jumps declare a wanted signal
// - detector also needs valid deviation and SNR above 7 dB to output 1
// - detector result can feed the signal-valid interrupt and receive extension
// - in direct mode with mute set, data output is silenced without wanted signal
// - recovered symbol clock drives decoding and can appear on a general pin
// - counting recovery assumes an exact rate and survives long runs of zeros
// - tracking recovery follows the sender rate within 15.6 % error
// - Manchester recovery is counting plus handling of sudden rate changes
// - frequency is base plus 2.5 kHz times step times channel index
// - direct-mode data drives a data pin assignable to general pins 1, 2 or 3
`timescale 1ns/1ps
module rxca_top #(
  parameter int NUM_GPIO = 3
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [rxca_pkg::RXCA_ADDR_W-1:0] reg_addr_i,
  input wire logic [rxca_pkg::RXCA_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [rxca_pkg::RXCA_DATA_W-1:0] reg_rdata_o,
  // demodulator side
  input wire rxca_pkg::rxca_demod_t demod_i,
  // assessment results
  output logic signal_valid_interrupt_o,
  output logic rx_extend_o,
  output logic [31:0] rf_freq_o,
  // recovered clock and data
  output logic cdr_clk_o,
  output logic cdr_data_o,
  output logic cdr_strobe_o,
  // general-purpose pins
  output logic [NUM_GPIO-1:0] gpio_o
);
  import rxca_pkg::*;

  // software registers
  logic [31:0] cfg_ff;
  logic [7:0] strength_threshold_ff;
  logic [7:0] hop_step_size_ff;
  logic [7:0] hop_channel_index_ff;
  logic [31:0] base_frequency_setting_ff;
  logic [7:0] dbm_cal_ff;
  logic [15:0] sym_period_ff;

  // config fields
  wire [2:0] strength_average_order = cfg_ff[CFG_AVG_LSB +: 3];
  wire rxca_capture_t strength_capture_select = rxca_capture_t'(cfg_ff[CFG_CAP_LSB +: 2]);
  wire [1:0] jump_window_select = cfg_ff[CFG_WIN_LSB +: 2];
  wire rxca_cdr_t cdr_mode = rxca_cdr_t'(cfg_ff[CFG_CDR_LSB +: 2]);
  wire dout_mute = cfg_ff[CFG_MUTE_BIT];
  wire irq_from_jump = cfg_ff[CFG_IRQ_SRC_BIT];
  wire ext_from_jump = cfg_ff[CFG_EXT_SRC_BIT];
  wire [1:0] dout_pin = cfg_ff[CFG_DOUT_PIN_LSB +: 2];
  wire [1:0] clk_pin = cfg_ff[CFG_CLK_PIN_LSB +: 2];

  // address decode
  wire wr_cfg = reg_wr_i && (reg_addr_i == OFF_CONFIG);
  wire wr_thr = reg_wr_i && (reg_addr_i == OFF_THRESH);
  wire wr_step = reg_wr_i && (reg_addr_i == OFF_HOP_STEP);
  wire wr_chan = reg_wr_i && (reg_addr_i == OFF_HOP_CHAN);
  wire wr_base = reg_wr_i && (reg_addr_i == OFF_BASE_FREQ);
  wire wr_cal = reg_wr_i && (reg_addr_i == OFF_DBM_CAL);
  wire wr_per = reg_wr_i && (reg_addr_i == OFF_SYM_PERIOD);

  // register writes; a period of zero would stall recovery, so it is floored at two
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_ff <= CONFIG_RST;
      strength_threshold_ff <= THRESH_RST;
      hop_step_size_ff <= 8'h00;
      hop_channel_index_ff <= 8'h00;
      base_frequency_setting_ff <= BASE_FREQ_RST;
      dbm_cal_ff <= DBM_CAL_RST;
      sym_period_ff <= SYM_PERIOD_RST;
    end else begin
      if (wr_cfg) cfg_ff <= reg_wdata_i;
      if (wr_thr) strength_threshold_ff <= reg_wdata_i[7:0];
      if (wr_step) hop_step_size_ff <= reg_wdata_i[7:0];
      if (wr_chan) hop_channel_index_ff <= reg_wdata_i[7:0];
      if (wr_base) base_frequency_setting_ff <= reg_wdata_i;
      if (wr_cal) dbm_cal_ff <= reg_wdata_i[7:0];
      if (wr_per) sym_period_ff <= (reg_wdata_i[15:0] < 16'h0002) ? 16'h0002 : reg_wdata_i[15:0];
    end
  end

  // signal strength
  logic [14:0] filt_acc_ff;
  logic [7:0] strength_code_ff;
  logic above_thr_ff;

  // sum of both channels; 7-bit levels keep the sum inside 8 bits
  wire [7:0] strength_raw_code = {1'b0, demod_i.i_level} + {1'b0, demod_i.q_level};
  // first-order recursive average, weight 2^-order; order 0 passes samples straight through
  wire signed [16:0] filt_diff = $signed({2'b00, strength_raw_code, 7'h00})
                               - $signed({2'b00, filt_acc_ff});
  wire signed [16:0] filt_step = filt_diff >>> strength_average_order;
  wire [16:0] filt_sum = 17'($signed({2'b00, filt_acc_ff}) + filt_step);
  wire [7:0] filt_code = filt_acc_ff[14:FILT_FRAC];
  // capture event chosen by the select field
  wire capture_evt = (strength_capture_select == CAP_PREAMBLE && demod_i.preamble_det)
                  || (strength_capture_select == CAP_SYNC && demod_i.sync_det)
                  || (strength_capture_select == CAP_PACKET && demod_i.packet_done);
  wire take_code = (strength_capture_select == CAP_REALTIME) || capture_evt;
  wire [7:0] strength_in_dbm = strength_code_ff - dbm_cal_ff;

  // filter, reported code and threshold compare
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      filt_acc_ff <= 15'h0000;
      strength_code_ff <= 8'h00;
      above_thr_ff <= 1'b0;
    end else begin
      if (demod_i.sample_vld) filt_acc_ff <= filt_sum[14:0];
      if (take_code) strength_code_ff <= filt_code;
      above_thr_ff <= (filt_code > strength_threshold_ff);
    end
  end

  // phase jump detector
  logic last_bit_ff;
  logic [16:0] since_jump_ff;
  logic [4:0] jump_cnt_ff;
  logic jump_valid_ff;

  wire phase_jump = demod_i.bit_vld && (demod_i.demod_bit != last_bit_ff);
  // a jump sooner than 3/4 symbol is off-rate; a gap of 8 symbols loses the signal
  wire [16:0] min_gap = {1'b0, sym_period_ff - (sym_period_ff >> 2)};
  wire [18:0] max_gap = {sym_period_ff, 3'b000};
  wire rate_ok = (since_jump_ff >= min_gap);
  wire gap_lost = ({2'b00, since_jump_ff} >= max_gap);
  wire [4:0] jumps_needed = 5'h02 << jump_window_select; // 2, 4, 8 or 16
  wire quality_ok = demod_i.fsk_mode && demod_i.dev_ok && demod_i.snr_ok;
  wire [4:0] nxt_jump_cnt = (!quality_ok || gap_lost || (phase_jump && !rate_ok)) ? 5'h00 :
                            (phase_jump && jump_cnt_ff != 5'h1f) ? jump_cnt_ff + 5'h01 :
                            jump_cnt_ff;

  // jump counting; count restarts on off-rate jumps, lost signal or bad deviation/SNR
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      last_bit_ff <= 1'b0;
      since_jump_ff <= 17'h0_0000;
      jump_cnt_ff <= 5'h00;
      jump_valid_ff <= 1'b0;
    end else begin
      if (demod_i.bit_vld) last_bit_ff <= demod_i.demod_bit;
      if (phase_jump) since_jump_ff <= 17'h0_0001;
      else if (!since_jump_ff[16]) since_jump_ff <= since_jump_ff + 17'h0_0001;
      jump_cnt_ff <= nxt_jump_cnt;
      jump_valid_ff <= quality_ok && (nxt_jump_cnt >= jumps_needed);
    end
  end

  // clock data recovery
  logic [15:0] phase_ff;
  logic [15:0] local_period_ff;
  logic cdr_clk_ff;
  logic cdr_data_ff;
  logic cdr_strobe_ff;

  // tracking limits: nominal period plus or minus 5/32 of it
  wire [15:0] trk_tol = 16'(({4'h0, sym_period_ff} * TRACK_TOL_NUM) >> TRACK_TOL_SHIFT);
  wire [15:0] trk_max = sym_period_ff + trk_tol;
  wire [15:0] trk_min = sym_period_ff - trk_tol;
  wire [15:0] half_period = local_period_ff >> 1;
  wire [15:0] quarter_period = local_period_ff >> 2;
  wire data_edge = phase_jump;
  wire phase_wrap = (phase_ff >= local_period_ff - 16'h0001);
  // manchester: resync on edges near the boundary, or when spacing says the rate jumped
  wire near_boundary = (phase_ff < quarter_period) || (phase_ff >= local_period_ff - quarter_period);
  wire rate_jumped = (since_jump_ff > {1'b0, local_period_ff + half_period});
  wire resync = data_edge && ((cdr_mode != CDR_MANCHESTER) || near_boundary || rate_jumped);
  // tracking: late edge lengthens the period, early edge shortens it, by 1/8 of the error
  wire [15:0] late_err = phase_ff >> 3;
  wire [15:0] early_err = (local_period_ff - phase_ff) >> 3;
  wire [15:0] trk_up = (local_period_ff + late_err > trk_max) ? trk_max : local_period_ff + late_err;
  wire [15:0] trk_dn = (local_period_ff - early_err < trk_min) ? trk_min : local_period_ff - early_err;
  wire [15:0] nxt_local_period = (cdr_mode != CDR_TRACKING) ? sym_period_ff :
                                 !data_edge ? local_period_ff :
                                 (phase_ff < half_period) ? trk_up : trk_dn;

  // phase counter free-runs on the exact period between edges, so long zero runs keep lock
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_ff <= 16'h0000;
      local_period_ff <= SYM_PERIOD_RST;
      cdr_clk_ff <= 1'b0;
      cdr_data_ff <= 1'b0;
      cdr_strobe_ff <= 1'b0;
    end else begin
      if (resync || phase_wrap) phase_ff <= 16'h0000;
      else phase_ff <= phase_ff + 16'h0001;
      local_period_ff <= nxt_local_period;
      cdr_clk_ff <= (phase_ff >= half_period);
      cdr_strobe_ff <= (phase_ff == half_period);
      if (phase_ff == half_period) cdr_data_ff <= last_bit_ff;
    end
  end

  // pins, results and frequency
  logic signal_valid_ff;
  logic rx_extend_ff;
  logic [31:0] rf_freq_ff;
  logic [NUM_GPIO-1:0] gpio_ff;

  wire dout_data = demod_i.direct_mode && dout_mute && !jump_valid_ff ? 1'b0 : last_bit_ff;
  wire [23:0] hop_prod = 24'(HOP_MULT * hop_step_size_ff * hop_channel_index_ff);
  wire [31:0] nxt_rf_freq = base_frequency_setting_ff + {8'h00, hop_prod};

  // pin k+1 carries the direct data if selected, else the recovered clock if selected
  genvar gi;
  generate
    for (gi = 0; gi < NUM_GPIO; gi++) begin : g_pin
      wire [1:0] pin_id = 2'(gi + 1);
      wire nxt_pin = (demod_i.direct_mode && dout_pin == pin_id) ? dout_data :
                     (clk_pin == pin_id) ? cdr_clk_ff : 1'b0;
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) gpio_ff[gi] <= 1'b0;
        else gpio_ff[gi] <= nxt_pin;
      end
    end
  endgenerate

  // result routing; hop frequency is recomputed each cycle so a channel write lands one cycle after the register takes it
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      signal_valid_ff <= 1'b0;
      rx_extend_ff <= 1'b0;
      rf_freq_ff <= BASE_FREQ_RST;
    end else begin
      signal_valid_ff <= irq_from_jump ? jump_valid_ff : above_thr_ff;
      rx_extend_ff <= ext_from_jump ? jump_valid_ff : above_thr_ff;
      rf_freq_ff <= nxt_rf_freq;
    end
  end

  // read path
  logic [31:0] rdata_ff;
  wire [31:0] status_word = {24'h00_0000, 3'b000, jump_cnt_ff[4:0] >= jumps_needed,
                             cdr_data_ff, jump_valid_ff, above_thr_ff, signal_valid_ff};
  wire [31:0] rd_mux = (reg_addr_i == OFF_CONFIG) ? cfg_ff :
                       (reg_addr_i == OFF_THRESH) ? {24'h00_0000, strength_threshold_ff} :
                       (reg_addr_i == OFF_HOP_STEP) ? {24'h00_0000, hop_step_size_ff} :
                       (reg_addr_i == OFF_HOP_CHAN) ? {24'h00_0000, hop_channel_index_ff} :
                       (reg_addr_i == OFF_BASE_FREQ) ? base_frequency_setting_ff :
                       (reg_addr_i == OFF_DBM_CAL) ? {24'h00_0000, dbm_cal_ff} :
                       (reg_addr_i == OFF_SYM_PERIOD) ? {16'h0000, sym_period_ff} :
                       (reg_addr_i == OFF_STATUS) ? status_word :
                       (reg_addr_i == OFF_STRENGTH) ? {16'h0000, strength_in_dbm, strength_code_ff} :
                       32'h0000_0000;

  // read data stands only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) rdata_ff <= 32'h0000_0000;
    else rdata_ff <= reg_rd_i ? rd_mux : 32'h0000_0000;
  end

  assign reg_rdata_o = rdata_ff;
  assign signal_valid_interrupt_o = signal_valid_ff;
  assign rx_extend_o = rx_extend_ff;
  assign rf_freq_o = rf_freq_ff;
  assign cdr_clk_o = cdr_clk_ff;
  assign cdr_data_o = cdr_data_ff;
  assign cdr_strobe_o = cdr_strobe_ff;
  assign gpio_o = gpio_ff;
endmodule : rxca_top

//--- testbench/rx_channel_assessment_tb_top.sv
// self-checking bench: registers, hop arithmetic, strength filter and capture, jump detector
`timescale 1ns/1ps
module rx_channel_assessment_tb_top;
  import rxca_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] reg_addr_i = 8'h00;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o, rf_freq_o, d, bs;
  logic signal_valid_interrupt_o, rx_extend_o, cdr_clk_o, cdr_data_o, cdr_strobe_o;
  logic [2:0] gpio_o;
  rxca_demod_t tmpl = '0;
  rxca_demod_t demod;
  logic toggle = 1'b0;
  logic seen_s, seen_g, seen_d;
  logic [7:0] code, a, b, t;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;
  // clock and a hang guard
  always #20 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("FAIL %0t run did not finish", $time);
      tally_and_finish();
    end
  end
  rxca_top #(.NUM_GPIO(3)) dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .demod_i(demod), .signal_valid_interrupt_o(signal_valid_interrupt_o), .rx_extend_o(rx_extend_o),
    .rf_freq_o(rf_freq_o), .cdr_clk_o(cdr_clk_o), .cdr_data_o(cdr_data_o),
    .cdr_strobe_o(cdr_strobe_o), .gpio_o(gpio_o));
  rxca_demod_model u_model (.core_clk_i(core_clk_i), .rst_i(rst_i), .tmpl_i(tmpl),
    .period_i(16'h0008), .toggle_i(toggle), .demod_o(demod));
  task automatic tally_and_finish();
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
    @(posedge core_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= dt;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] ad);
    @(posedge core_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask : rd
  task automatic smp(input logic [7:0] i, input logic [7:0] q);
    @(posedge core_clk_i);
    tmpl.i_level <= i[6:0];
    tmpl.q_level <= q[6:0];
    tmpl.sample_vld <= 1'b1;
    @(posedge core_clk_i);
    tmpl.sample_vld <= 1'b0;
    repeat (4) @(posedge core_clk_i);
  endtask : smp
  // one-cycle receive event: 1 preamble, 2 sync, 3 packet end
  task automatic ev(input int m);
    @(posedge core_clk_i);
    {tmpl.preamble_det, tmpl.sync_det, tmpl.packet_done} <= 3'b100 >> (m - 1);
    @(posedge core_clk_i);
    {tmpl.preamble_det, tmpl.sync_det, tmpl.packet_done} <= 3'b000;
    repeat (3) @(posedge core_clk_i);
  endtask : ev
  // watch strobe and data pin at the falling edge, where outputs are settled
  task automatic run(input int n);
    seen_s = 1'b0;
    seen_g = 1'b0;
    seen_d = 1'b0;
    repeat (n) begin
      @(negedge core_clk_i);
      seen_s |= cdr_strobe_o === 1'b1;
      seen_d |= cdr_data_o === 1'b1;
      seen_g |= gpio_o[0] === 1'b1;
    end
  endtask : run
  function automatic logic [31:0] cfgw(input int avg, cap, win, cdr, mute, src);
    return 32'h0210_0000 | 32'(avg) | 32'(cap) << CFG_CAP_LSB | 32'(win) << CFG_WIN_LSB
      | 32'(cdr) << CFG_CDR_LSB | 32'(mute) << CFG_MUTE_BIT | 32'(src) * 32'h0006_0000;
  endfunction : cfgw
  function automatic logic [31:0] hop_exp(input logic [31:0] bf, input logic [7:0] st, ch);
    return bf + 32'(st) * 32'(ch) * 32'(HOP_UNIT_HZ / FREQ_LSB_HZ);
  endfunction : hop_exp
  initial begin
    void'($urandom(95));
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(OFF_CONFIG); chk(d, CONFIG_RST);
    rd(OFF_THRESH); chk(d, {24'h00_0000, THRESH_RST});
    rd(OFF_DBM_CAL); chk(d, {24'h00_0000, DBM_CAL_RST});
    rd(OFF_SYM_PERIOD); chk(d, {16'h0000, SYM_PERIOD_RST});
    rd(8'h24); chk(d, 32'h0000_0000);
    $display("test reset values done");
    // full-scale corner first, then random step, channel and base
    for (int k = 0; k < 5; k++) begin
      a = (k == 0) ? 8'hff : 8'($urandom);
      b = (k == 0) ? 8'hff : 8'($urandom);
      bs = 32'($urandom_range(0, 32'h00ff_ffff));
      wr(OFF_HOP_STEP, {24'h00_0000, a});
      // the frequency-loop parameter lives outside this block; the base is rewritten per hop
      wr(OFF_BASE_FREQ, bs);
      wr(OFF_HOP_CHAN, {24'h00_0000, b});
      repeat (3) @(posedge core_clk_i);
      #1 chk(rf_freq_o, hop_exp(bs, a, b));
      rd(OFF_HOP_CHAN); chk(d, {24'h00_0000, b});
    end
    $display("test hop frequency done");
    // first the top levels with the top threshold, then threshold equal to the code
    for (int k = 0; k < 5; k++) begin
      a = (k == 0) ? 8'd127 : 8'($urandom_range(0, 127));
      b = (k == 0) ? 8'd127 : 8'($urandom_range(0, 127));
      code = a + b;
      t = (k == 0) ? 8'hff : (k == 1) ? code : 8'($urandom);
      wr(OFF_THRESH, {24'h00_0000, t});
      smp(a, b);
      rd(OFF_STRENGTH); chk(d, {16'h0000, code - DBM_CAL_RST, code});
      rd(OFF_STATUS); chk(d[1], code > t);
      chk(signal_valid_interrupt_o, code > t);
      chk(rx_extend_o, code > t);
    end
    wr(OFF_CONFIG, cfgw(1, 0, 1, 0, 0, 0));
    smp(8'd3, 8'd4);
    code = 8'((9'(code) + 9'd7) >> 1);
    rd(OFF_STRENGTH); chk(d[7:0], code);
    $display("test strength and threshold done");
    for (int m = 1; m < 4; m++) begin
      wr(OFF_CONFIG, cfgw(0, m, 1, 0, 0, 0));
      a = 8'($urandom_range(0, 127));
      smp(a, 8'd1);
      ev(m == 3 ? 1 : m + 1);
      rd(OFF_STRENGTH); chk(d[7:0], code);
      ev(m);
      code = a + 8'd1;
      rd(OFF_STRENGTH); chk(d[7:0], code);
    end
    $display("test strength capture done");
    wr(OFF_SYM_PERIOD, 32'h0000_0008);
    @(posedge core_clk_i) tmpl.fsk_mode <= 1'b1;
    @(posedge core_clk_i) {tmpl.dev_ok, tmpl.snr_ok, tmpl.direct_mode} <= 3'b111;
    @(posedge core_clk_i) toggle <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      wr(OFF_CONFIG, cfgw(0, 0, 1, c, 1, 1));
      run(96);
      chk(seen_s, 1'b1);
      chk(seen_d, 1'b1);
      chk(signal_valid_interrupt_o, 1'b1);
      chk(rx_extend_o, 1'b1);
      chk(seen_g, 1'b1);
    end
    // every window size: below the jump count nothing, above it the result
    for (int s = 0; s < 4; s++) begin
      wr(OFF_CONFIG, cfgw(0, 0, s, 0, 1, 1));
      @(posedge core_clk_i) toggle <= 1'b0;
      run(80);
      chk(seen_s, 1'b1);
      chk(signal_valid_interrupt_o, 1'b0);
      @(posedge core_clk_i) toggle <= 1'b1;
      run((2 << s) * 8 - 12);
      chk(signal_valid_interrupt_o, 1'b0);
      run(40);
      chk(signal_valid_interrupt_o, 1'b1);
    end
    @(posedge core_clk_i) tmpl.snr_ok <= 1'b0;
    run(16);
    run(48);
    chk(seen_g, 1'b0);
    chk(signal_valid_interrupt_o, 1'b0);
    rd(OFF_STATUS); chk(d[2], 1'b0);
    wr(OFF_CONFIG, cfgw(0, 0, 3, 0, 0, 1));
    run(48);
    chk(seen_g, 1'b1);
    $display("test jump detector and recovery done");
    tally_and_finish();
  end
endmodule : rx_channel_assessment_tb_top

//--- testbench/rxca_chk.sv
// concurrent checks on the ports of the receive channel assessment block
`timescale 1ns/1ps
module rxca_chk #(
  parameter int NUM_GPIO = 3
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [rxca_pkg::RXCA_ADDR_W-1:0] reg_addr_i,
  input wire logic [rxca_pkg::RXCA_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [rxca_pkg::RXCA_DATA_W-1:0] reg_rdata_o,
  // demodulator and results
  input wire rxca_pkg::rxca_demod_t demod_i,
  input wire logic signal_valid_interrupt_o,
  input wire logic rx_extend_o,
  input wire logic [31:0] rf_freq_o,
  input wire logic cdr_clk_o,
  input wire logic cdr_data_o,
  input wire logic cdr_strobe_o,
  input wire logic [NUM_GPIO-1:0] gpio_o
);
  import rxca_pkg::*;
  logic [31:0] cfg_ff, base_ff;
  logic [7:0] thr_ff, step_ff, chan_ff;
  wire logic ok = demod_i.fsk_mode & demod_i.dev_ok & demod_i.snr_ok;
  wire logic mapped = reg_addr_i <= OFF_STRENGTH && reg_addr_i[1:0] == 2'b00;
  wire logic thr_top = thr_ff == 8'hff;
  // shadow of the config, threshold, hop and base fields, so expectations follow software writes
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_ff <= CONFIG_RST;
      base_ff <= BASE_FREQ_RST;
      thr_ff <= THRESH_RST;
      step_ff <= 8'h00;
      chan_ff <= 8'h00;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        OFF_CONFIG: cfg_ff <= reg_wdata_i;
        OFF_THRESH: thr_ff <= reg_wdata_i[7:0];
        OFF_HOP_STEP: step_ff <= reg_wdata_i[7:0];
        OFF_HOP_CHAN: chan_ff <= reg_wdata_i[7:0];
        OFF_BASE_FREQ: base_ff <= reg_wdata_i;
        default: ;
      endcase
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data not zero outside the answer cycle");
  unmapped_rd_a: assert property ($past(reg_rd_i) && !$past(mapped) |-> reg_rdata_o == '0)
    else $error("unmapped read gave data");
  chan_rb_a: assert property (reg_rd_i && reg_addr_i == OFF_HOP_CHAN |=>
    reg_rdata_o == {24'h00_0000, chan_ff}) else $error("channel index readback wrong");
  hop_freq_a: assert property (!$past(reg_wr_i) && !$past(reg_wr_i, 2) |->
    rf_freq_o == base_ff + 32'(step_ff) * 32'(chan_ff) * 32'(HOP_MULT))
    else $error("hop frequency wrong");
  jump_gate_a: assert property ((cfg_ff[CFG_IRQ_SRC_BIT] && !ok)[*4] |=>
    !signal_valid_interrupt_o) else $error("jump result high without valid signal");
  mute_data_a: assert property ((cfg_ff[CFG_MUTE_BIT] && cfg_ff[CFG_DOUT_PIN_LSB +: 2] == 2'd1
    && demod_i.direct_mode && !ok)[*4] |=> !gpio_o[0]) else $error("muted data pin active");
  thr_max_a: assert property ((!cfg_ff[CFG_IRQ_SRC_BIT] && thr_top && demod_i.sample_vld)
    ##1 (!cfg_ff[CFG_IRQ_SRC_BIT] && thr_top)[*3] |=> !signal_valid_interrupt_o)
    else $error("strength above top threshold");
  ext_max_a: assert property ((!cfg_ff[CFG_EXT_SRC_BIT] && thr_top && demod_i.sample_vld)
    ##1 (!cfg_ff[CFG_EXT_SRC_BIT] && thr_top)[*3] |=> !rx_extend_o)
    else $error("extension above top threshold");
  strobe_pulse_a: assert property (cdr_strobe_o |=> !cdr_strobe_o)
    else $error("recovery strobe longer than one cycle");
  data_hold_a: assert property (!cdr_strobe_o |-> $stable(cdr_data_o))
    else $error("recovered data changed without a strobe");
  // pin 2 carries the recovered clock one cycle late unless direct data claims it
  clk_pin_a: assert property (cfg_ff[CFG_CLK_PIN_LSB +: 2] == 2'd2
    && !(demod_i.direct_mode && cfg_ff[CFG_DOUT_PIN_LSB +: 2] == 2'd2)
    |=> gpio_o[1] == $past(cdr_clk_o))
    else $error("clock pin does not follow the recovered clock");
  // main scenarios reached
  cover property (signal_valid_interrupt_o && cfg_ff[CFG_IRQ_SRC_BIT]);
  cover property (cdr_strobe_o);
  cover property (reg_wr_i && reg_addr_i == OFF_HOP_CHAN);
endmodule : rxca_chk
bind rxca_top rxca_chk #(.NUM_GPIO(NUM_GPIO)) u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .demod_i(demod_i), .signal_valid_interrupt_o(signal_valid_interrupt_o),
  .rx_extend_o(rx_extend_o), .rf_freq_o(rf_freq_o), .cdr_clk_o(cdr_clk_o),
  .cdr_data_o(cdr_data_o), .cdr_strobe_o(cdr_strobe_o), .gpio_o(gpio_o));

//--- testbench/rxca_demod_model.sv
// behavioural demodulator: passes the bench template and can send a toggling bit stream
`timescale 1ns/1ps
module rxca_demod_model (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // control from the bench
  input wire rxca_pkg::rxca_demod_t tmpl_i,
  input wire logic [15:0] period_i,
  input wire logic toggle_i,
  // towards the block
  output rxca_pkg::rxca_demod_t demod_o
);
  import rxca_pkg::*;
  logic [15:0] cnt_ff;
  logic bit_ff;
  // one bit per period; flipping every bit makes each bit a phase jump
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= 16'h0000;
      bit_ff <= 1'b0;
    end else if (cnt_ff + 16'h0001 >= period_i) begin
      cnt_ff <= 16'h0000;
      bit_ff <= toggle_i ? ~bit_ff : bit_ff;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
  // valid only in the first cycle of a bit, and silent while the stream is off
  always_comb begin
    demod_o = tmpl_i;
    demod_o.demod_bit = bit_ff;
    demod_o.bit_vld = toggle_i && cnt_ff == 16'h0000;
  end
endmodule : rxca_demod_model
